//--- src/aite_cfg.svh
// offsets, field positions, reset values and timing counts of the input timing engine
`ifndef AITE_CFG_SVH
`define AITE_CFG_SVH
`define AITE_CTRL_OFS 12'h000
`define AITE_SRC_OFS 12'h004
`define AITE_SDIV_OFS 12'h008
`define AITE_CDIV_OFS 12'h00C
`define AITE_SDLY_OFS 12'h010
`define AITE_CDLY_OFS 12'h014
`define AITE_POST_OFS 12'h018
`define AITE_PRE_OFS 12'h01C
`define AITE_NCONV_OFS 12'h020
`define AITE_ROUTE_OFS 12'h024
`define AITE_STAT_OFS 12'h028
`define AITE_CMD_OFS 12'h02C
`define AITE_SDLY_RST 32'h0000_0004
`define AITE_CDLY_RST 32'h0000_0003
`define AITE_NCONV_RST 32'h0000_0001
`define AITE_DIV_RST 32'h0000_0064
// ctrl fields
`define AITE_C_CONT 0
`define AITE_C_RETRIG 1
`define AITE_C_PRETRIG 2
`define AITE_C_USETRIG 3
`define AITE_C_SPOL 4
`define AITE_C_CPOL 5
`define AITE_C_BPOL 6
`define AITE_C_TPOL 7
`define AITE_C_HPOL 8
`define AITE_C_CBSEL 9
`define AITE_C_AUTOSTOP 10
// cmd fields
`define AITE_K_START 0
`define AITE_K_STOP 1
`define AITE_K_SWCLK 2
`define AITE_K_CLROVR 3
// reference tick periods in ns
`define AITE_PCLK_NS 10
`define AITE_REF20_NS 50
`define AITE_REF100K_NS 10000
`define AITE_REF20_CNT (`AITE_REF20_NS / `AITE_PCLK_NS)
`define AITE_REF100K_CNT (`AITE_REF100K_NS / `AITE_PCLK_NS)
`endif

//--- src/aite_pkg.sv
// types of the input timing engine
package aite_pkg;
   typedef enum logic [3:0] {
      AITE_ST_IDLE = 4'h1,
      AITE_ST_WAIT_TRIG = 4'h2,
      AITE_ST_DELAY = 4'h4,
      AITE_ST_RUN = 4'h8
   } aite_state_t;
   typedef enum logic [2:0] {
      AITE_SS_DIV = 3'h0,
      AITE_SS_CTR = 3'h1,
      AITE_SS_SW = 3'h2,
      AITE_SS_CHG = 3'h3,
      AITE_SS_SUB = 3'h4,
      AITE_SS_LINE = 3'h5
   } aite_ssrc_t;
   typedef enum logic [1:0] {
      AITE_TB_100M = 2'h0,
      AITE_TB_20M = 2'h1,
      AITE_TB_100K = 2'h2,
      AITE_TB_LINE = 2'h3
   } aite_tbsrc_t;
   // internal event sources offered to the selectors
   typedef struct packed {
      logic ctr_out;
      logic chg_event;
      logic output_update_strobe;
      logic digital_in_strobe;
      logic digital_out_strobe;
   } aite_int_src_t;
   // routing of exported signals: enable and line number each
   typedef struct packed {
      logic hold_en;
      logic [3:0] hold_line;
      logic trig_en;
      logic [3:0] trig_line;
      logic conv_en;
      logic [3:0] conv_line;
      logic samp_en;
      logic [3:0] samp_line;
   } aite_route_t;
endpackage

//--- src/aite_engine.sv
// analog input timing engine with apb register slave
// How it works
// - each sample strobe samples all task channels via sample output pulse
// - sample strobe edge is selectable rising or falling
// - sample source: divider, counter, software, change, subsystems, or lines 0..15
// - exported sample and trigger pulses high; exported convert strobe active low
// - sample events outside an acquisition are ignored
// - trigger starts sample counter; hardware or software stops finite run
// - trigger to first internal sample delay in base ticks, reset four
// - sample base: 100 MHz default, 20 MHz, 100 kHz, or a line; never exported
// - base edge selectable only on a line base; the 100 kHz and fast references tick with fixed polarity
// - each convert pulse starts one conversion; edge selectable
// - convert strobe is a one-cycle pulse; exported line returns high after each conversion
// - convert divider starts on sample, counts to zero, reloads, repeats
// - convert source: divider, counter, change, subsystems, or lines 0..15
// - sample to first internal convert delay in convert base ticks, reset three
// - sample and convert events ignored before a valid trigger
// - converts ignored before a sample and after the sample completes
// - new sample before conversions finish raises scan overrun
// - convert base is the sample base or 100 MHz; never exported
// - hold done pulse after each conversion, polarity selectable, routable
// - start on trigger or software; finite by count, continuous until stop
// - retriggerable: each trigger runs full generation; triggers during it ignored
// - trigger source line, counter or internal, edge selectable
// - pre-trigger: load pre count on trigger, then post count
// - software start drives pulse on internal trigger line
`include "aite_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module aite_engine (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] digital_line_pins_in,
   output logic [15:0] digital_line_pins_out,
   output logic [15:0] digital_line_pins_oe,
   input wire aite_pkg::aite_int_src_t int_src,
   output logic input_sample_strobe,
   output logic conversion_strobe,
   output logic acquisition_begin_trigger,
   output logic hold_done_pulse,
   output logic scan_overrun
);
   logic [31:0] ctrl_reg, src_reg, sdiv_reg, cdiv_reg, sdly_reg, cdly_reg;
   logic [31:0] post_reg, pre_reg, nconv_reg;
   aite_pkg::aite_route_t route_reg;
   aite_pkg::aite_state_t state_reg;
   logic [15:0] sync1_reg, sync2_reg, sync3_reg;
   logic [31:0] ref20_reg, ref100k_reg, sdiv_cnt_reg, cdiv_cnt_reg, dly_cnt_reg, samp_cnt_reg;
   logic [31:0] conv_left_reg, cdly_cnt_reg;
   logic pre_phase_reg, cdly_reg_act, sw_clk_reg, sw_trig_reg;
   logic prev_s_reg, prev_c_reg, prev_t_reg, prev_b_reg;
   logic wr, rd, cmd_start, cmd_stop;
   function automatic logic sel_line(input logic [15:0] v, input logic [3:0] n);
      sel_line = v[n];
   endfunction
   // one-cycle active event from a level and its previous value at chosen edge
   function automatic logic edge_ev(input logic now, input logic prev, input logic fall);
      edge_ev = fall ? (prev & ~now) : (now & ~prev);
   endfunction
   function automatic logic int_pick(input logic [2:0] s, input aite_pkg::aite_int_src_t i);
      case (s)
         3'h1: int_pick = i.ctr_out;
         3'h3: int_pick = i.chg_event;
         3'h4: int_pick = i.output_update_strobe;
         3'h6: int_pick = i.digital_in_strobe;
         3'h7: int_pick = i.digital_out_strobe;
         default: int_pick = 1'b0;
      endcase
   endfunction
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~pwrite;
   assign cmd_start = wr && paddr == `AITE_CMD_OFS && pwdata[`AITE_K_START];
   assign cmd_stop = wr && paddr == `AITE_CMD_OFS && pwdata[`AITE_K_STOP];
   // apb: zero wait states; unmapped addresses read zero and flag pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= 32'h0000_0400;
         src_reg <= 32'h0000_0000;
         sdiv_reg <= `AITE_DIV_RST;
         cdiv_reg <= `AITE_DIV_RST;
         sdly_reg <= `AITE_SDLY_RST;
         cdly_reg <= `AITE_CDLY_RST;
         post_reg <= 32'h0000_0001;
         pre_reg <= 32'h0000_0000;
         nconv_reg <= `AITE_NCONV_RST;
         route_reg <= '0;
      end else if (wr) begin
         case (paddr)
            `AITE_CTRL_OFS: ctrl_reg <= pwdata;
            `AITE_SRC_OFS: src_reg <= pwdata;
            `AITE_SDIV_OFS: sdiv_reg <= pwdata;
            `AITE_CDIV_OFS: cdiv_reg <= pwdata;
            `AITE_SDLY_OFS: sdly_reg <= pwdata;
            `AITE_CDLY_OFS: cdly_reg <= pwdata;
            `AITE_POST_OFS: post_reg <= pwdata;
            `AITE_PRE_OFS: pre_reg <= pwdata;
            `AITE_NCONV_OFS: nconv_reg <= pwdata;
            `AITE_ROUTE_OFS: route_reg <= pwdata[19:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel & ~penable) begin
            case (paddr)
               `AITE_CTRL_OFS: prdata <= ctrl_reg;
               `AITE_SRC_OFS: prdata <= src_reg;
               `AITE_SDIV_OFS: prdata <= sdiv_reg;
               `AITE_CDIV_OFS: prdata <= cdiv_reg;
               `AITE_SDLY_OFS: prdata <= sdly_reg;
               `AITE_CDLY_OFS: prdata <= cdly_reg;
               `AITE_POST_OFS: prdata <= post_reg;
               `AITE_PRE_OFS: prdata <= pre_reg;
               `AITE_NCONV_OFS: prdata <= nconv_reg;
               `AITE_ROUTE_OFS: prdata <= {12'h000, route_reg};
               `AITE_STAT_OFS: prdata <= {23'h0, pre_phase_reg, state_reg, 3'h0, scan_overrun};
               `AITE_CMD_OFS: prdata <= 32'h0000_0000;
               default: pslverr <= 1'b1;
            endcase
            if (!rd) prdata <= 32'h0000_0000;
         end
      end
   end
   // line inputs: first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 16'h0000;
         sync2_reg <= 16'h0000;
         sync3_reg <= 16'h0000;
      end else begin
         sync1_reg <= digital_line_pins_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end
   // src_reg: [2:0] sample src, [7:4] sample line, [9:8] base src, [15:12] base line,
   // [18:16] convert src, [23:20] convert line, [26:24] trig src, [31:28] trig line
   logic base_raw, base_ev, ref20_tick, ref100k_tick, cbase_ev;
   logic s_raw, s_ev, c_raw, c_ev, t_raw, t_ev;
   logic int_samp, int_conv, running, fast_base;
   aite_pkg::aite_tbsrc_t tbs;
   assign tbs = aite_pkg::aite_tbsrc_t'(src_reg[9:8]);
   assign ref20_tick = ref20_reg == 32'h0000_0000;
   assign ref100k_tick = ref100k_reg == 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref20_reg <= 32'h0000_0000;
         ref100k_reg <= 32'h0000_0000;
      end else begin
         ref20_reg <= ref20_tick ? 32'(`AITE_REF20_CNT - 1) : ref20_reg - 32'h0000_0001;
         ref100k_reg <= ref100k_tick ? 32'(`AITE_REF100K_CNT - 1) : ref100k_reg - 32'h0000_0001;
      end
   end
   // all three references tick with fixed polarity; only a line base honours the base edge
   assign fast_base = (tbs == aite_pkg::AITE_TB_100M) || (tbs == aite_pkg::AITE_TB_20M);
   always_comb begin
      case (tbs)
         aite_pkg::AITE_TB_100M: base_raw = 1'b1;
         aite_pkg::AITE_TB_20M: base_raw = ref20_tick;
         aite_pkg::AITE_TB_100K: base_raw = ref100k_tick;
         default: base_raw = sel_line(sync2_reg, src_reg[15:12]);
      endcase
   end
   assign base_ev = fast_base ? base_raw :
      (tbs == aite_pkg::AITE_TB_LINE ?
       edge_ev(base_raw, sel_line(sync3_reg, src_reg[15:12]), ctrl_reg[`AITE_C_BPOL]) :
       base_raw);
   assign cbase_ev = ctrl_reg[`AITE_C_CBSEL] ? 1'b1 : base_ev;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sw_clk_reg <= 1'b0;
      else sw_clk_reg <= wr && paddr == `AITE_CMD_OFS && pwdata[`AITE_K_SWCLK];
   end
   assign running = state_reg == aite_pkg::AITE_ST_RUN;
   // internal divider tick, gated by run state
   assign int_samp = running && base_ev && sdiv_cnt_reg == 32'h0000_0000;
   always_comb begin
      case (src_reg[2:0])
         3'h0: s_raw = int_samp;
         3'h2: s_raw = sw_clk_reg;
         3'h5: s_raw = sel_line(sync2_reg, src_reg[7:4]);
         default: s_raw = int_pick(src_reg[2:0], int_src);
      endcase
      case (src_reg[18:16])
         3'h0: c_raw = int_conv;
         3'h5: c_raw = sel_line(sync2_reg, src_reg[23:20]);
         default: c_raw = int_pick(src_reg[18:16], int_src);
      endcase
      case (src_reg[26:24])
         3'h5: t_raw = sel_line(sync2_reg, src_reg[31:28]);
         default: t_raw = int_pick(src_reg[26:24], int_src);
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_s_reg <= 1'b0;
         prev_c_reg <= 1'b0;
         prev_t_reg <= 1'b0;
      end else begin
         prev_s_reg <= s_raw;
         prev_c_reg <= c_raw;
         prev_t_reg <= t_raw;
      end
   end
   // internal divider pulses are already single events; others pass the chosen edge
   assign s_ev = (src_reg[2:0] == 3'h0) ? s_raw :
                 edge_ev(s_raw, prev_s_reg, ctrl_reg[`AITE_C_SPOL]);
   assign c_ev = (src_reg[18:16] == 3'h0) ? c_raw :
                 edge_ev(c_raw, prev_c_reg, ctrl_reg[`AITE_C_CPOL]);
   assign t_ev = edge_ev(t_raw, prev_t_reg, ctrl_reg[`AITE_C_TPOL]);
   logic samp_ok, conv_ok, conv_busy, last_samp;
   assign conv_busy = conv_left_reg != 32'h0000_0000;
   assign samp_ok = running && s_ev;
   assign conv_ok = running && c_ev && conv_busy;
   assign last_samp = samp_ok && !pre_phase_reg && !ctrl_reg[`AITE_C_CONT] &&
                      samp_cnt_reg == 32'h0000_0001;
   // acquisition sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= aite_pkg::AITE_ST_IDLE;
         dly_cnt_reg <= 32'h0000_0000;
         samp_cnt_reg <= 32'h0000_0000;
         pre_phase_reg <= 1'b0;
         sw_trig_reg <= 1'b0;
      end else begin
         sw_trig_reg <= 1'b0;
         if (cmd_stop) begin
            state_reg <= aite_pkg::AITE_ST_IDLE;
         end else begin
            case (state_reg)
               aite_pkg::AITE_ST_IDLE: begin
                  if (cmd_start) begin
                     if (ctrl_reg[`AITE_C_USETRIG]) begin
                        state_reg <= aite_pkg::AITE_ST_WAIT_TRIG;
                     end else begin
                        sw_trig_reg <= 1'b1;
                        state_reg <= aite_pkg::AITE_ST_DELAY;
                        dly_cnt_reg <= sdly_reg;
                        pre_phase_reg <= ctrl_reg[`AITE_C_PRETRIG];
                        samp_cnt_reg <= ctrl_reg[`AITE_C_PRETRIG] ? pre_reg : post_reg;
                     end
                  end
               end
               aite_pkg::AITE_ST_WAIT_TRIG: begin
                  if (t_ev) begin
                     state_reg <= aite_pkg::AITE_ST_DELAY;
                     dly_cnt_reg <= sdly_reg;
                     pre_phase_reg <= ctrl_reg[`AITE_C_PRETRIG];
                     samp_cnt_reg <= ctrl_reg[`AITE_C_PRETRIG] ? pre_reg : post_reg;
                  end
               end
               aite_pkg::AITE_ST_DELAY: begin
                  if (base_ev) begin
                     if (dly_cnt_reg <= 32'h0000_0001) state_reg <= aite_pkg::AITE_ST_RUN;
                     dly_cnt_reg <= dly_cnt_reg - 32'h0000_0001;
                  end
               end
               aite_pkg::AITE_ST_RUN: begin
                  if (samp_ok && !ctrl_reg[`AITE_C_CONT]) begin
                     if (pre_phase_reg && samp_cnt_reg <= 32'h0000_0001) begin
                        pre_phase_reg <= 1'b0;
                        samp_cnt_reg <= post_reg;
                     end else begin
                        samp_cnt_reg <= samp_cnt_reg - 32'h0000_0001;
                     end
                  end
                  // finite end: retrigger rearms, autostop idles, else park in delay with an all-ones count
                  if (last_samp && ctrl_reg[`AITE_C_RETRIG]) begin
                     state_reg <= aite_pkg::AITE_ST_WAIT_TRIG;
                  end else if (last_samp && ctrl_reg[`AITE_C_AUTOSTOP]) begin
                     state_reg <= aite_pkg::AITE_ST_IDLE;
                  end else if (last_samp) begin
                     state_reg <= aite_pkg::AITE_ST_DELAY;
                     dly_cnt_reg <= 32'hFFFF_FFFF;
                  end
               end
               default: state_reg <= aite_pkg::AITE_ST_IDLE;
            endcase
         end
      end
   end
   // sample divider counts base ticks only while running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sdiv_cnt_reg <= 32'h0000_0000;
      else if (!running) sdiv_cnt_reg <= 32'h0000_0000;
      else if (base_ev) begin
         sdiv_cnt_reg <= (sdiv_cnt_reg == 32'h0000_0000) ?
                         sdiv_reg - 32'h0000_0001 : sdiv_cnt_reg - 32'h0000_0001;
      end
   end
   // convert divider: delay after sample, then count to zero and reload per conversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_left_reg <= 32'h0000_0000;
         cdiv_cnt_reg <= 32'h0000_0000;
         cdly_cnt_reg <= 32'h0000_0000;
         cdly_reg_act <= 1'b0;
         scan_overrun <= 1'b0;
      end else begin
         if (samp_ok && conv_busy) scan_overrun <= 1'b1;
         else if (wr && paddr == `AITE_CMD_OFS && pwdata[`AITE_K_CLROVR]) scan_overrun <= 1'b0;
         if (!running) begin
            conv_left_reg <= 32'h0000_0000;
            cdly_reg_act <= 1'b0;
         end else if (samp_ok) begin
            conv_left_reg <= nconv_reg;
            cdly_cnt_reg <= cdly_reg;
            cdly_reg_act <= 1'b1;
            cdiv_cnt_reg <= cdiv_reg - 32'h0000_0001;
         end else begin
            if (conv_ok) conv_left_reg <= conv_left_reg - 32'h0000_0001;
            if (cbase_ev && conv_busy) begin
               if (cdly_reg_act) begin
                  if (cdly_cnt_reg <= 32'h0000_0001) cdly_reg_act <= 1'b0;
                  cdly_cnt_reg <= cdly_cnt_reg - 32'h0000_0001;
               end else begin
                  cdiv_cnt_reg <= (cdiv_cnt_reg == 32'h0000_0000) ?
                                  cdiv_reg - 32'h0000_0001 : cdiv_cnt_reg - 32'h0000_0001;
               end
            end else if (!conv_busy) begin
               cdiv_cnt_reg <= cdiv_reg - 32'h0000_0001;
            end
         end
      end
   end
   // first convert fires as the delay expires, later ones at divider zero
   assign int_conv = running && conv_busy && cbase_ev &&
                     (cdly_reg_act ? cdly_cnt_reg <= 32'h0000_0001 :
                      cdiv_cnt_reg == 32'h0000_0000);
   // strobes and exported lines
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_sample_strobe <= 1'b0;
         conversion_strobe <= 1'b0;
         acquisition_begin_trigger <= 1'b0;
         hold_done_pulse <= 1'b0;
         prev_b_reg <= 1'b0;
         digital_line_pins_out <= 16'h0000;
         digital_line_pins_oe <= 16'h0000;
      end else begin
         input_sample_strobe <= samp_ok;
         conversion_strobe <= conv_ok;
         acquisition_begin_trigger <= sw_trig_reg ||
            (state_reg == aite_pkg::AITE_ST_WAIT_TRIG && t_ev);
         prev_b_reg <= conv_ok;
         hold_done_pulse <= prev_b_reg ^ ctrl_reg[`AITE_C_HPOL];
         for (int i = 0; i < 16; i++) begin
            digital_line_pins_oe[i] <= (route_reg.samp_en && route_reg.samp_line == 4'(i)) ||
                                       (route_reg.conv_en && route_reg.conv_line == 4'(i)) ||
                                       (route_reg.trig_en && route_reg.trig_line == 4'(i)) ||
                                       (route_reg.hold_en && route_reg.hold_line == 4'(i));
            digital_line_pins_out[i] <=
               (route_reg.samp_en && route_reg.samp_line == 4'(i) && samp_ok) ||
               (route_reg.conv_en && route_reg.conv_line == 4'(i) && !conv_ok) ||
               (route_reg.trig_en && route_reg.trig_line == 4'(i) &&
                (sw_trig_reg || (state_reg == aite_pkg::AITE_ST_WAIT_TRIG && t_ev))) ||
               (route_reg.hold_en && route_reg.hold_line == 4'(i) &&
                (prev_b_reg ^ ctrl_reg[`AITE_C_HPOL]));
         end
      end
   end
   sample_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !running && s_ev |=> !input_sample_strobe) else $error("sample passed while idle");
   overrun_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      samp_ok && conv_busy |=> scan_overrun) else $error("overrun not flagged");
   conv_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      c_ev && !conv_busy |=> !conversion_strobe) else $error("stray convert passed");
   hold_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      conversion_strobe |=> hold_done_pulse != $past(ctrl_reg[`AITE_C_HPOL]))
      else $error("hold pulse missing");
   begin_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == aite_pkg::AITE_ST_IDLE && cmd_start && !cmd_stop &&
      !ctrl_reg[`AITE_C_USETRIG] |-> ##2 acquisition_begin_trigger) else $error("no start pulse");
   conv_export_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_ok && route_reg.conv_en && !route_reg.samp_en && !route_reg.trig_en &&
      !route_reg.hold_en |=> !digital_line_pins_out[$past(route_reg.conv_line)])
      else $error("convert export not low");
endmodule
`default_nettype wire

//--- bench/aite_line_model.sv
// behavioural model of the external sources on the digital lines
`timescale 1ns/100ps
`default_nettype none
module aite_line_model (
   input wire logic clk,
   output logic [15:0] lines
);
   initial lines = '0;
   // held for several cycles so the two-stage synchroniser cannot miss it
   task automatic pulse(input int n, input int len);
      @(posedge clk);
      lines[n] <= 1'b1;
      repeat (len) @(posedge clk);
      lines[n] <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the input timing engine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, smp, cnv, trg, hld, scan_overrun;
   logic [15:0] pins_in, pins_out, pins_oe;
   logic [32:0] expq[$];
   logic [32:0] n_samp = '0, n_conv = '0, n_trig = '0, n_hold = '0, cdiv;
   int fails = 0, n_checks = 0, cyc = 0, i;
   aite_pkg::aite_int_src_t isrc = '0;
   always #5 pclk = ~pclk;
   aite_engine aite_engine_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .digital_line_pins_in(pins_in),
      .digital_line_pins_out(pins_out), .digital_line_pins_oe(pins_oe), .int_src(isrc),
      .input_sample_strobe(smp), .conversion_strobe(cnv), .acquisition_begin_trigger(trg),
      .hold_done_pulse(hld), .scan_overrun(scan_overrun));
   aite_line_model aite_line_model_inst (.clk(pclk), .lines(pins_in));
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) expq.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // result monitor: every completed read retires the oldest expectation
   always @(posedge pclk) begin
      cyc++;
      if (smp === 1'b1) n_samp <= n_samp + 1;
      if (cnv === 1'b1) n_conv <= n_conv + 1;
      if (trg === 1'b1) n_trig <= n_trig + 1;
      if (hld === 1'b1) n_hold <= n_hold + 1;
      if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
         check({pslverr, prdata}, expq.pop_front());
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      void'($urandom(32'h7788));
      settle(16);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0, 33'h0_0000_0400);
      apb(1'b0, 12'h010, 32'h0, 33'h0_0000_0004);
      apb(1'b0, 12'h014, 32'h0, 33'h0_0000_0003);
      apb(1'b0, 12'h030, 32'h0, 33'h1_0000_0000);
      $display("test reset values done");
      apb(1'b1, 12'h004, 32'h0000_0002, '0);
      apb(1'b1, 12'h02C, 32'h0000_0004, '0);
      settle(40);
      check(n_samp, 33'h0);
      $display("test idle sample done");
      cdiv = {1'b0, 32'd2 + ($urandom % 4)};
      apb(1'b1, 12'h00C, cdiv[31:0], '0);
      apb(1'b0, 12'h00C, 32'h0, cdiv);
      apb(1'b1, 12'h024, 32'h0000_02A0, '0);
      apb(1'b1, 12'h000, 32'h0000_0401, '0);
      apb(1'b1, 12'h02C, 32'h0000_0001, '0);
      settle(30);
      check(n_trig, 33'h1);
      apb(1'b0, 12'h028, 32'h0, 33'h0_0000_0080);
      apb(1'b1, 12'h02C, 32'h0000_0004, '0);
      for (i = 0; i < 500 && n_conv !== 33'h1; i++) @(posedge pclk);
      settle(40);
      check(n_samp, 33'h1);
      check(n_conv, 33'h1);
      check(n_hold, 33'h1);
      check({1'b0, pins_oe, pins_out}, 33'h0_0020_0020);
      $display("test software run done");
      apb(1'b1, 12'h00C, 32'h0000_0064, '0);
      apb(1'b1, 12'h020, 32'h0000_0004, '0);
      apb(1'b1, 12'h02C, 32'h0000_0004, '0);
      apb(1'b1, 12'h02C, 32'h0000_0004, '0);
      settle(2);
      check({32'h0, scan_overrun}, 33'h1);
      settle(900);
      apb(1'b1, 12'h02C, 32'h0000_0008, '0);
      settle(2);
      check({32'h0, scan_overrun}, 33'h0);
      $display("test overrun done");
      apb(1'b1, 12'h00C, cdiv[31:0], '0);
      apb(1'b1, 12'h020, 32'h0000_0001, '0);
      apb(1'b1, 12'h004, 32'h0000_0035, '0);
      i = n_samp[31:0];
      aite_line_model_inst.pulse(3, 4);
      settle(20);
      check(n_samp, 33'(i + 1));
      apb(1'b1, 12'h004, 32'h0000_0001, '0);
      isrc.ctr_out <= 1'b1;
      settle(4);
      check(n_samp, 33'(i + 2));
      apb(1'b1, 12'h02C, 32'h0000_0002, '0);
      apb(1'b0, 12'h028, 32'h0, 33'h0_0000_0010);
      $display("test line clock and stop done");
      report_and_stop();
   end
endmodule
`default_nettype wire
